// *** include/ddi_regs.svh ***
`ifndef DDI_REGS_SVH
`define DDI_REGS_SVH

// ----------------------------------------------------------------
// data word layout and reset values
// ----------------------------------------------------------------
`define DDI_DATA_W   10
`define DDI_CODE_MAX 10'h3FF
`define DDI_CODE_RST 10'h000

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define DDI_LATENCY  4

`endif

// *** include/ddi_pkg.sv ***
`include "ddi_regs.svh"

package ddi_pkg;

  typedef logic [`DDI_DATA_W-1:0] ddi_code_t;

  // converter clock divider phase
  typedef enum logic [1:0] {
    DDI_DIV_HELD,
    DDI_DIV_LOW,
    DDI_DIV_HIGH
  } ddi_div_t;

  typedef struct packed {
    ddi_code_t comp_b;
    ddi_code_t true_b;
    ddi_code_t comp_a;
    ddi_code_t true_a;
  } ddi_word_t;

endpackage : ddi_pkg

// *** include/ddi_stream_if.sv ***
interface ddi_stream_if;
  import ddi_pkg::*;

  logic      valid;
  logic      ready;
  ddi_word_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);

endinterface : ddi_stream_if

// *** design/ddi_pair_buffer.sv ***
// two-entry buffer: an output register plus one skid register
module ddi_pair_buffer
  import ddi_pkg::*;
(
  input  logic       sys_clk,
  input  logic       rst,
  input  logic       ce,
  ddi_stream_if.snk  push,
  output logic       out_valid,
  output ddi_word_t  out_data,
  input  logic       out_ready
);

  logic      skid_valid;
  ddi_word_t skid_data;
  logic      next_out_valid;
  ddi_word_t next_out_data;
  logic      next_skid_valid;
  ddi_word_t next_skid_data;
  logic      take;

  // ready depends on flops only, so no path runs from out_ready to push
  assign push.ready = ~skid_valid;
  assign take       = push.valid & ~skid_valid;

  always_comb begin
    next_out_valid  = out_valid;
    next_out_data   = out_data;
    next_skid_valid = skid_valid;
    next_skid_data  = skid_data;
    if (!out_valid || out_ready) begin
      if (skid_valid) begin
        next_out_valid  = 1'h1;
        next_out_data   = skid_data;
        next_skid_valid = 1'h0;
      end else begin
        next_out_valid = take;
        if (take) begin
          next_out_data = push.data;
        end
      end
    end else if (take) begin
      next_skid_valid = 1'h1;
      next_skid_data  = push.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid  <= 1'h0;
      out_data   <= '0;
      skid_valid <= 1'h0;
      skid_data  <= '0;
    end else if (ce) begin
      out_valid  <= next_out_valid;
      out_data   <= next_out_data;
      skid_valid <= next_skid_valid;
      skid_data  <= next_skid_data;
    end
  end

  stall_hold_a: assert property (@(posedge sys_clk) disable iff (rst || !ce)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer output changed while stalled");

endmodule : ddi_pair_buffer

// *** design/ddi_core.sv ***
`include "ddi_regs.svh"

module ddi_core
  import ddi_pkg::*;
#(
  parameter int LATENCY = `DDI_LATENCY
) (
  input  logic      sys_clk,
  input  logic      rst,
  input  logic      ce,
  input  ddi_code_t bus_a,
  input  ddi_code_t bus_b,
  input  logic      write_strobe_a,
  input  logic      write_strobe_b,
  input  logic      update_clock_a,
  input  logic      update_clock_b,
  input  logic      shared_write_strobe,
  input  logic      shared_update_clock,
  input  logic      channel_select,
  input  logic      pairing_reset,
  input  logic      mode_select,
  input  logic      gain_mode_select,
  input  logic      out_ready,
  output ddi_code_t output_current_true_a,
  output ddi_code_t output_current_complement_a,
  output ddi_code_t output_current_true_b,
  output ddi_code_t output_current_complement_b,
  output logic      out_valid,
  output logic      input_ready,
  output logic      divided_converter_clock,
  output logic      dual_mode_active,
  output logic      b_uses_set_resistor_a,
  output logic      overrun
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int B    = 2 * `DDI_DATA_W;
  localparam int NPIN = B + 10;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [5:0]      strobe_prev;

  assign pin_raw = {gain_mode_select, mode_select, pairing_reset, channel_select,
                    shared_update_clock, shared_write_strobe, update_clock_b,
                    update_clock_a, write_strobe_b, write_strobe_a, bus_b, bus_a};

  // data and strobes share the same two-stage delay, so alignment holds
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta    <= '0;
      pin_sync    <= '0;
      strobe_prev <= '0;
    end else if (ce) begin
      pin_meta    <= pin_raw;
      pin_sync    <= pin_meta;
      strobe_prev <= pin_sync[B+5:B];
    end
  end

  ddi_code_t  bus_a_s;
  ddi_code_t  bus_b_s;
  logic       sel_s;
  logic       prst_s;
  logic       mode_s;
  logic       gain_s;
  logic [5:0] rise;
  logic [5:0] fall;

  assign bus_a_s = pin_sync[`DDI_DATA_W-1:0];
  assign bus_b_s = pin_sync[B-1:`DDI_DATA_W];
  assign sel_s   = pin_sync[B+6];
  assign prst_s  = pin_sync[B+7];
  assign mode_s  = pin_sync[B+8];
  assign gain_s  = pin_sync[B+9];

  function automatic logic [5:0] edge_bits(input logic [5:0] prev, input logic [5:0] cur,
                                           input logic up);
    edge_bits = up ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_bits

  // one accepted edge per strobe transition; the pin rate is bounded by sys_clk
  // sampling, far below the converter's own 275 MSPS ceiling
  assign rise = edge_bits(strobe_prev, pin_sync[B+5:B], 1'h1);
  assign fall = edge_bits(strobe_prev, pin_sync[B+5:B], 1'h0);

  // ----------------------------------------------------------------
  // input latches and interleave staging
  // ----------------------------------------------------------------
  ddi_code_t in_a;
  ddi_code_t in_b;
  ddi_code_t staged_a;
  ddi_code_t staged_b;
  ddi_code_t next_in_a;
  ddi_code_t next_in_b;
  ddi_code_t next_staged_a;
  ddi_code_t next_staged_b;

  always_comb begin
    next_in_a     = in_a;
    next_in_b     = in_b;
    next_staged_a = staged_a;
    next_staged_b = staged_b;
    if (mode_s) begin
      if (rise[0]) begin
        next_in_a = bus_a_s;
      end
      if (rise[1]) begin
        next_in_b = bus_b_s;
      end
    end else begin
      // the B bus is ignored here; both channels arrive on A
      if (rise[4]) begin
        if (sel_s) begin
          next_in_a = bus_a_s;
        end else begin
          next_in_b = bus_a_s;
        end
      end
      if (fall[4]) begin
        next_staged_a = in_a;
        next_staged_b = in_b;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_a     <= `DDI_CODE_RST;
      in_b     <= `DDI_CODE_RST;
      staged_a <= `DDI_CODE_RST;
      staged_b <= `DDI_CODE_RST;
    end else if (ce) begin
      in_a     <= next_in_a;
      in_b     <= next_in_b;
      staged_a <= next_staged_a;
      staged_b <= next_staged_b;
    end
  end

  // ----------------------------------------------------------------
  // divided converter clock
  // ----------------------------------------------------------------
  ddi_div_t div_state;
  ddi_div_t next_div_state;
  logic     next_div_clk;
  logic     div_load;

  always_comb begin
    next_div_state = div_state;
    if (mode_s || prst_s) begin
      next_div_state = DDI_DIV_HELD;
    end else if (rise[5]) begin
      unique case (div_state)
        // first shared clock after release always rises: fixed pairing phase
        DDI_DIV_HELD: next_div_state = DDI_DIV_HIGH;
        DDI_DIV_LOW:  next_div_state = DDI_DIV_HIGH;
        DDI_DIV_HIGH: next_div_state = DDI_DIV_LOW;
      endcase
    end
    next_div_clk = (next_div_state == DDI_DIV_HIGH);
    div_load     = next_div_clk && (div_state != DDI_DIV_HIGH);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_state               <= DDI_DIV_HELD;
      divided_converter_clock <= 1'h0;
    end else if (ce) begin
      div_state               <= next_div_state;
      divided_converter_clock <= next_div_clk;
    end
  end

  // ----------------------------------------------------------------
  // converter latches and output pipeline
  // ----------------------------------------------------------------
  ddi_code_t pipe_a [LATENCY];
  ddi_code_t pipe_b [LATENCY];
  ddi_code_t next_pipe_a [LATENCY];
  ddi_code_t next_pipe_b [LATENCY];
  logic      load_a;
  logic      load_b;
  ddi_code_t src_a;
  ddi_code_t src_b;

  // interleaved mode feeds words at twice the divided rate, two per load
  assign load_a = mode_s ? rise[2] : div_load;
  assign load_b = mode_s ? rise[3] : div_load;
  // registered latch value: an update coinciding with a write takes the older word
  assign src_a  = mode_s ? in_a : staged_a;
  assign src_b  = mode_s ? in_b : staged_b;

  always_comb begin
    next_pipe_a = pipe_a;
    next_pipe_b = pipe_b;
    if (load_a) begin
      next_pipe_a[0] = src_a;
      for (int i = 1; i < LATENCY; i++) begin
        next_pipe_a[i] = pipe_a[i-1];
      end
    end
    if (load_b) begin
      next_pipe_b[0] = src_b;
      for (int i = 1; i < LATENCY; i++) begin
        next_pipe_b[i] = pipe_b[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_a[i] <= `DDI_CODE_RST;
        pipe_b[i] <= `DDI_CODE_RST;
      end
    end else if (ce) begin
      pipe_a <= next_pipe_a;
      pipe_b <= next_pipe_b;
    end
  end

  // ----------------------------------------------------------------
  // decode, status and buffer
  // ----------------------------------------------------------------
  // plain offset binary: the code itself steers the true output
  function automatic ddi_code_t complement_of(input ddi_code_t code);
    complement_of = `DDI_CODE_MAX - code;
  endfunction : complement_of

  ddi_stream_if link ();
  ddi_word_t    out_word;
  logic         push_valid;
  logic         next_push_valid;
  logic         next_overrun;

  assign link.valid       = push_valid;
  assign link.data.true_a = pipe_a[LATENCY-1];
  assign link.data.comp_a = complement_of(pipe_a[LATENCY-1]);
  assign link.data.true_b = pipe_b[LATENCY-1];
  assign link.data.comp_b = complement_of(pipe_b[LATENCY-1]);

  always_comb begin
    next_push_valid = load_a | load_b;
    // a word offered while the buffer is full is lost; the flag makes it visible
    next_overrun    = overrun | (push_valid & ~link.ready);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      push_valid            <= 1'h0;
      overrun               <= 1'h0;
      input_ready           <= 1'h0;
      dual_mode_active      <= 1'h0;
      b_uses_set_resistor_a <= 1'h0;
    end else if (ce) begin
      push_valid            <= next_push_valid;
      overrun               <= next_overrun;
      input_ready           <= link.ready;
      dual_mode_active      <= mode_s;
      b_uses_set_resistor_a <= gain_s;
    end
  end

  ddi_pair_buffer u_buffer (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .push      (link.snk),
    .out_valid (out_valid),
    .out_data  (out_word),
    .out_ready (out_ready)
  );

  assign output_current_true_a       = out_word.true_a;
  assign output_current_complement_a = out_word.comp_a;
  assign output_current_true_b       = out_word.true_b;
  assign output_current_complement_b = out_word.comp_b;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || !ce);

  sequence sel_write;
    !mode_s && rise[4] && sel_s;
  endsequence

  sequence strobe_fall;
    !mode_s && fall[4];
  endsequence

  latch_capture_a: assert property (mode_s && rise[0] |=> in_a == $past(bus_a_s))
    else $error("dual mode latch A missed its word");
  steer_sel_a: assert property (!mode_s && rise[4] && !sel_s |=> in_b == $past(bus_a_s))
    else $error("low select did not steer A bus to B latch");
  hold_other_a: assert property (sel_write |=> in_b == $past(in_b))
    else $error("unselected latch changed");
  // covers a strobe that stands high three sampled cycles; shorter pulses leave it vacuous
  fall_stage_a: assert property (sel_write ##1 (!rise[4])[*2] ##1 strobe_fall
                                 |=> staged_a == $past(bus_a_s, 4))
    else $error("falling strobe did not pass captured word on");
  div_held_a: assert property (prst_s |=> !divided_converter_clock)
    else $error("divided clock high under pairing reset");
  div_pair_a: assert property (!mode_s && !prst_s && div_state == DDI_DIV_HELD && rise[5]
                               |=> divided_converter_clock ##1 divided_converter_clock)
    else $error("divided clock phase not fixed after release");
  div_toggle_a: assert property (!mode_s && !prst_s && rise[5] && div_state != DDI_DIV_HELD
                                 |=> divided_converter_clock != $past(divided_converter_clock))
    else $error("divided clock did not toggle");
  joint_load_a: assert property (!mode_s && div_load
                                 |=> pipe_a[0] == $past(staged_a) && pipe_b[0] == $past(staged_b))
    else $error("converter latches did not load together");
  decode_sum_a: assert property (out_valid |-> {1'h0, output_current_true_a}
                                 + {1'h0, output_current_complement_a} == 11'h3FF)
    else $error("true and complement codes do not sum to full scale");

endmodule : ddi_core

// *** dv/ddi_source.sv ***
// ----------------------------------------------------------------
// sample source on the far side of the pins
// ----------------------------------------------------------------
module ddi_source
  import ddi_pkg::*;
(
  input  wire logic sys_clk,
  output ddi_code_t bus_a,
  output ddi_code_t bus_b,
  output logic      write_strobe_a,
  output logic      write_strobe_b,
  output logic      update_clock_a,
  output logic      update_clock_b,
  output logic      shared_write_strobe,
  output logic      shared_update_clock,
  output logic      channel_select
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bus_a = '0;
    bus_b = '0;
    {write_strobe_a, write_strobe_b, update_clock_a, update_clock_b} = '0;
    {shared_write_strobe, shared_update_clock, channel_select} = '0;
  end

  // strobe and clock move together, so the clock is never after the write
  task automatic set_edge(input logic lvl, input logic dual);
    if (dual) begin
      {write_strobe_a, write_strobe_b, update_clock_a, update_clock_b} <= {4{lvl}};
    end else begin
      {shared_write_strobe, shared_update_clock} <= {2{lvl}};
    end
    // three edges: the pins are synchronised before the edge is seen
    repeat (3) @(posedge sys_clk);
  endtask : set_edge

  // interleaved: b is junk, only the a bus carries samples
  task automatic put(input ddi_code_t a, input ddi_code_t b, input logic sel, input logic dual);
    @(posedge sys_clk);
    bus_a          <= a;
    bus_b          <= dual ? b : ~b;
    channel_select <= sel;
    repeat (2) @(posedge sys_clk);
    set_edge(1'h1, dual);
    set_edge(1'h0, dual);
    // a released bus must not keep showing the old word
    bus_a <= ~a;
    bus_b <= ~bus_b;
  endtask : put

endmodule : ddi_source

// *** dv/dual_dac_input_interface_bench.sv ***
`include "ddi_regs.svh"

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end

module dual_dac_input_interface_bench import ddi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic      sys_clk = 1'h0;
  logic      rst, mode_select, gain_mode_select, pairing_reset, out_ready;
  logic      write_strobe_a, write_strobe_b, update_clock_a, update_clock_b;
  logic      shared_write_strobe, shared_update_clock, channel_select;
  logic      out_valid, input_ready, divided_converter_clock;
  logic      dual_mode_active, b_uses_set_resistor_a, overrun;
  ddi_code_t bus_a, bus_b;
  ddi_code_t output_current_true_a, output_current_complement_a;
  ddi_code_t output_current_true_b, output_current_complement_b;
  ddi_word_t got[$];
  ddi_word_t exp[$];
  ddi_code_t corner[4] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF};
  int        n_errors = 0;
  int        compares = 0;
  int        cycles = 0;
  logic      stall = 1'h1;
  logic      watch = 1'h0;
  logic      div_prev = 1'h0;
  int        div_rises = 0;

  ddi_core #(.LATENCY(`DDI_LATENCY)) ddi_core_i (
    .sys_clk(sys_clk), .rst(rst), .ce(1'h1), .bus_a(bus_a), .bus_b(bus_b),
    .write_strobe_a(write_strobe_a), .write_strobe_b(write_strobe_b),
    .update_clock_a(update_clock_a), .update_clock_b(update_clock_b),
    .shared_write_strobe(shared_write_strobe), .shared_update_clock(shared_update_clock),
    .channel_select(channel_select), .pairing_reset(pairing_reset), .mode_select(mode_select),
    .gain_mode_select(gain_mode_select), .out_ready(out_ready),
    .output_current_true_a(output_current_true_a), .output_current_complement_a(output_current_complement_a),
    .output_current_true_b(output_current_true_b), .output_current_complement_b(output_current_complement_b),
    .out_valid(out_valid), .input_ready(input_ready), .divided_converter_clock(divided_converter_clock),
    .dual_mode_active(dual_mode_active), .b_uses_set_resistor_a(b_uses_set_resistor_a), .overrun(overrun));

  ddi_source ddi_source_i (
    .sys_clk(sys_clk), .bus_a(bus_a), .bus_b(bus_b),
    .write_strobe_a(write_strobe_a), .write_strobe_b(write_strobe_b),
    .update_clock_a(update_clock_a), .update_clock_b(update_clock_b),
    .shared_write_strobe(shared_write_strobe), .shared_update_clock(shared_update_clock),
    .channel_select(channel_select));

  // ----------------------------------------------------------------
  // clock, sink, watchers
  // ----------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    out_ready <= stall ? 1'h0 : ($urandom_range(3) != 0);
    if (!rst && out_valid && out_ready) begin
      got.push_back({output_current_complement_b, output_current_true_b,
                     output_current_complement_a, output_current_true_a});
    end
    // one divided clock rise is expected per A/B pair
    div_prev <= divided_converter_clock;
    if (divided_converter_clock && !div_prev) begin
      div_rises++;
    end
    cycles++;
    // the whole run needs about 530 cycles
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  always @(negedge sys_clk) begin
    if (watch) begin
      `CHK("divided clock held", 1'h0, divided_converter_clock)
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic ddi_word_t mk(input ddi_code_t a, input ddi_code_t b);
    return {`DDI_CODE_MAX - b, b, `DDI_CODE_MAX - a, a};
  endfunction : mk

  task automatic do_reset(input logic m, input logic g);
    @(posedge sys_clk);
    rst              <= 1'h1;
    mode_select      <= m;
    gain_mode_select <= g;
    pairing_reset    <= ~m;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    got.delete();
    exp.delete();
    `CHK("mode", m, dual_mode_active)
    `CHK("gain", g, b_uses_set_resistor_a)
    `CHK("valid after reset", 1'h0, out_valid)
  endtask : do_reset

  task automatic end_test(input string s);
    $display("test %s done, compares %0d", s, compares);
  endtask : end_test

  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    ddi_code_t a;
    ddi_code_t b;
    int        k;
    {rst, mode_select, gain_mode_select, pairing_reset, out_ready} = 5'h13;
    void'($urandom(32'h1bb7));

    // dual bus: every write is one update, output trails by the latency
    do_reset(1'h1, 1'h1);
    stall = 1'h0;
    for (int i = 0; i < 16; i++) begin
      a = (i < 4) ? corner[i] : 10'($urandom);
      b = (i < 4) ? corner[3 - i] : 10'($urandom);
      ddi_source_i.put(a, b, 1'h0, 1'h1);
      exp.push_back(mk(a, b));
    end
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("dual count", 16, got.size())
    for (int i = 0; i < 16; i++) begin
      `CHK("dual word", (i < `DDI_LATENCY) ? mk(0, 0) : exp[i - `DDI_LATENCY], got[i])
    end
    end_test("dual");

    // interleaved: divider held, then A/B words at twice the divided clock rate, one pair per divided clock
    do_reset(1'h0, 1'h0);
    watch = 1'h1;
    ddi_source_i.put(10'h155, 10'h0AA, 1'h1, 1'h0);
    ddi_source_i.put(10'h2AA, 10'h155, 1'h0, 1'h0);
    watch = 1'h0;
    pairing_reset <= 1'h0;
    repeat (4) @(posedge sys_clk);
    div_rises = 0;
    for (int i = 0; i < 14; i++) begin
      a = (i == 1) ? 10'h3FF : 10'($urandom);
      b = (i == 1) ? 10'h000 : 10'($urandom);
      ddi_source_i.put(a, 10'($urandom), 1'h1, 1'h0);
      ddi_source_i.put(b, 10'($urandom), 1'h0, 1'h0);
      exp.push_back(mk(a, b));
    end
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    for (k = 0; k < got.size(); k++) begin
      if (got[k] === exp[0]) begin
        break;
      end
    end
    `CHK("pairs seen", 1'h1, got.size() >= k + 8)
    for (int j = 0; j < 8; j++) begin
      `CHK("pair", exp[j], got[k + j])
    end
    `CHK("pair offset", `DDI_LATENCY, k)
    `CHK("preload pair", mk(10'h155, 10'h2AA), got[k - 1])
    `CHK("div rises", 14, div_rises)
    end_test("interleaved");

    // receiver stalls: buffer fills, extra words are dropped
    do_reset(1'h1, 1'h0);
    stall = 1'h1;
    repeat (5) ddi_source_i.put(10'($urandom), 10'($urandom), 1'h0, 1'h1);
    @(negedge sys_clk);
    `CHK("buffer full", 1'h0, input_ready)
    `CHK("overrun set", 1'h1, overrun)
    `CHK("valid held", 1'h1, out_valid)
    stall = 1'h0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("drained", 1'h0, out_valid)
    `CHK("ready again", 1'h1, input_ready)
    `CHK("overrun sticky", 1'h1, overrun)
    `CHK("kept words", 2, got.size())
    end_test("stall");
    finish_test();
  end

endmodule : dual_dac_input_interface_bench
